/* File: rtl/bcc_host.sv */
/*
 * host controller of the backup cache control register: takes orders over
 * apb, drives processor-register cycles into the cache tag controller.
 * assumes one clock, a device that acknowledges each cycle, and inputs
 * synchronous to clk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "bcc_defs.svh"

module bcc_host
    import bcc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mem_slow_ram,
    input wire logic pcache_on,
    output logic pcache_flush,
    output logic pr_req,
    output logic pr_write,
    output logic [`BCC_PR_AW-1:0] pr_addr,
    output logic [31:0] pr_wdata,
    input wire logic pr_ack,
    input wire logic [31:0] pr_rdata
);
    // ************************************************************
    // declarations
    // ************************************************************
    bcc_state_t state_reg;
    bcc_state_t state_next;
    logic [`BCC_CTL_W-1:0] target_reg;
    logic [`BCC_CTL_W-1:0] shadow_reg;
    logic [`BCC_CTL_W-1:0] target_next;
    logic need_pt_reg;
    logic need_wr_reg;
    logic pending_reg;
    logic refused_reg;
    logic allow_off_reg;
    logic soft_ref_on_reg;
    logic [31:0] readback_reg;
    logic [`BCC_ROW_W-1:0] row_reg;
    logic [`BCC_TMR_W-1:0] tmr_reg;
    logic due_reg;
    logic apb_prep;
    logic apb_fire;
    logic wr_req;
    logic wr_cmd;
    logic wr_status;
    logic wr_refcfg;
    logic idle;
    logic issue;
    logic cyc_write;
    logic [`BCC_PR_AW-1:0] cyc_addr;
    logic [31:0] cyc_wdata;
    logic cyc_done;
    logic [31:0] cyc_rdata;
    logic [31:0] rd_mux;
    logic rd_err;

    assign idle = (state_reg == BCC_IDLE);
    assign apb_prep = psel && penable && !pready;
    assign apb_fire = psel && penable && pready;
    assign wr_req = apb_fire && pwrite && (paddr == `BCC_OFF_CTRL_REQ);
    assign wr_cmd = apb_fire && pwrite && (paddr == `BCC_OFF_CMD);
    assign wr_status = apb_fire && pwrite && (paddr == `BCC_OFF_STATUS);
    assign wr_refcfg = apb_fire && pwrite && (paddr == `BCC_OFF_REFRESH_CFG);

    // ************************************************************
    // requested control value, made safe
    // ************************************************************
    always_comb
    begin
        target_next = pwdata[`BCC_CTL_W-1:0];
        target_next[`BCC_SLOW_RAM_SELECT] = mem_slow_ram;
        if (pcache_on)
        begin
            target_next[`BCC_PRIMARY_TAG_COPY_ON] = 1'b1;
        end
        if (shadow_reg[`BCC_BACKUP_TAG_ON] && !pwdata[`BCC_REQ_ALLOW_OFF])
        begin
            target_next[`BCC_BACKUP_TAG_ON] = 1'b1;
        end
        if (!target_next[`BCC_BACKUP_TAG_ON])
        begin
            target_next[`BCC_FORCE_HIT] = 1'b0;
        end
    end

    // ************************************************************
    // apb slave, one wait state
    // ************************************************************
    always_comb
    begin
        rd_mux = 32'h0;
        rd_err = 1'b0;
        case (paddr)
            `BCC_OFF_CTRL_REQ:
            begin
                rd_mux[`BCC_CTL_W-1:0] = target_reg;
                rd_mux[`BCC_REQ_ALLOW_OFF] = allow_off_reg;
            end
            `BCC_OFF_CMD:
            begin
                rd_mux = 32'h0;
            end
            `BCC_OFF_STATUS:
            begin
                rd_mux[`BCC_ST_BUSY] = !idle;
                rd_mux[`BCC_ST_REFUSED] = refused_reg;
                rd_mux[`BCC_ST_CTL_LSB +: `BCC_CTL_W] = shadow_reg;
                rd_mux[`BCC_ST_ROW_LSB +: `BCC_ROW_W] = row_reg;
            end
            `BCC_OFF_READBACK:
            begin
                rd_mux = readback_reg;
            end
            `BCC_OFF_REFRESH_CFG:
            begin
                rd_mux[0] = soft_ref_on_reg;
            end
            default:
            begin
                rd_err = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= apb_prep;
            prdata <= apb_prep && !pwrite ? rd_mux : 32'h0;
            pslverr <= apb_prep && rd_err;
        end
    end

    // ************************************************************
    // configuration and refused flag
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            soft_ref_on_reg <= 1'b1;
            refused_reg <= 1'b0;
        end
        else
        begin
            if (wr_refcfg)
            begin
                soft_ref_on_reg <= pwdata[0];
            end
            // set wins over clear
            if ((wr_req || wr_cmd) && !idle)
            begin
                refused_reg <= 1'b1;
            end
            else if (wr_status && pwdata[`BCC_ST_REFUSED])
            begin
                refused_reg <= 1'b0;
            end
        end
    end

    // ************************************************************
    // sequence state
    // ************************************************************
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            BCC_IDLE:
            begin
                if (wr_cmd && pwdata[`BCC_CMD_FLUSH_BT])
                begin
                    state_next = BCC_FLUSH_BT;
                end
                else if (wr_cmd && pwdata[`BCC_CMD_FLUSH_PT])
                begin
                    state_next = BCC_FLUSH_PT;
                end
                else if (wr_cmd && pwdata[`BCC_CMD_READ])
                begin
                    state_next = BCC_RD_CTL;
                end
                else if (wr_req && ((target_next[`BCC_BACKUP_TAG_ON] && !shadow_reg[`BCC_BACKUP_TAG_ON])
                    || (shadow_reg[`BCC_FORCE_HIT] && !target_next[`BCC_FORCE_HIT])))
                begin
                    state_next = BCC_FLUSH_BT;
                end
                else if (wr_req && target_next[`BCC_PRIMARY_TAG_COPY_ON]
                    && !shadow_reg[`BCC_PRIMARY_TAG_COPY_ON])
                begin
                    state_next = BCC_FLUSH_PT;
                end
                else if (wr_req)
                begin
                    state_next = BCC_WR_CTL;
                end
                else if (due_reg)
                begin
                    state_next = BCC_REF_ROW;
                end
            end
            BCC_FLUSH_BT:
            begin
                if (cyc_done)
                begin
                    state_next = need_pt_reg ? BCC_FLUSH_PT : (need_wr_reg ? BCC_WR_CTL : BCC_IDLE);
                end
            end
            BCC_FLUSH_PT:
            begin
                if (cyc_done)
                begin
                    state_next = need_wr_reg ? BCC_PC_FLUSH : BCC_IDLE;
                end
            end
            BCC_PC_FLUSH:
            begin
                state_next = BCC_WR_CTL;
            end
            BCC_WR_CTL:
            begin
                if (cyc_done)
                begin
                    state_next = BCC_RD_CTL;
                end
            end
            BCC_RD_CTL:
            begin
                if (cyc_done)
                begin
                    state_next = BCC_IDLE;
                end
            end
            BCC_REF_ROW:
            begin
                if (cyc_done)
                begin
                    state_next = BCC_REF_TAG;
                end
            end
            BCC_REF_TAG:
            begin
                if (cyc_done)
                begin
                    state_next = BCC_IDLE;
                end
            end
            default:
            begin
                state_next = BCC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= BCC_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ************************************************************
    // sequence flags and target
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            target_reg <= `BCC_CTL_RESET;
            allow_off_reg <= 1'b0;
            need_pt_reg <= 1'b0;
            need_wr_reg <= 1'b0;
        end
        else if (idle && wr_req && !wr_cmd)
        begin
            target_reg <= target_next;
            allow_off_reg <= pwdata[`BCC_REQ_ALLOW_OFF];
            need_pt_reg <= target_next[`BCC_PRIMARY_TAG_COPY_ON] && !shadow_reg[`BCC_PRIMARY_TAG_COPY_ON];
            need_wr_reg <= 1'b1;
        end
        else if (idle && wr_cmd)
        begin
            need_pt_reg <= pwdata[`BCC_CMD_FLUSH_BT] && pwdata[`BCC_CMD_FLUSH_PT];
            need_wr_reg <= 1'b0;
        end
    end

    // ************************************************************
    // device cycles
    // ************************************************************
    assign issue = !idle && (state_reg != BCC_PC_FLUSH) && !pending_reg;

    always_comb
    begin
        cyc_write = 1'b1;
        cyc_addr = `BCC_PR_CTL;
        cyc_wdata = 32'h0;
        case (state_reg)
            BCC_FLUSH_BT:
            begin
                cyc_addr = `BCC_PR_FLUSH_BT;
            end
            BCC_FLUSH_PT:
            begin
                cyc_addr = `BCC_PR_FLUSH_PT;
            end
            BCC_WR_CTL:
            begin
                cyc_wdata[`BCC_CTL_W-1:0] = target_reg;
            end
            BCC_RD_CTL:
            begin
                cyc_write = 1'b0;
            end
            BCC_REF_ROW:
            begin
                cyc_addr = `BCC_PR_ROW_CTR;
                cyc_wdata[`BCC_ROW_W-1:0] = row_reg;
            end
            BCC_REF_TAG:
            begin
                cyc_write = 1'b0;
                cyc_addr = `BCC_PR_TAG_DATA;
            end
            default:
            begin
                cyc_write = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pending_reg <= 1'b0;
        end
        else if (cyc_done)
        begin
            pending_reg <= 1'b0;
        end
        else if (issue)
        begin
            pending_reg <= 1'b1;
        end
    end

    bcc_cycle u_cycle
    (
        .clk(clk),
        .rst_n(rst_n),
        .start(issue),
        .write(cyc_write),
        .addr(cyc_addr),
        .wdata(cyc_wdata),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .pr_req(pr_req),
        .pr_write(pr_write),
        .pr_addr(pr_addr),
        .pr_wdata(pr_wdata),
        .pr_ack(pr_ack),
        .pr_rdata(pr_rdata)
    );

    // ************************************************************
    // primary cache flush pulse
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pcache_flush <= 1'b0;
        end
        else
        begin
            pcache_flush <= (state_reg == BCC_PC_FLUSH);
        end
    end

    // ************************************************************
    // readback and shadow
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // device resets these bits to zero
            shadow_reg <= `BCC_CTL_RESET;
            readback_reg <= 32'h0;
        end
        else if (cyc_done && (state_reg == BCC_RD_CTL))
        begin
            shadow_reg <= cyc_rdata[`BCC_CTL_W-1:0];
            readback_reg <= cyc_rdata;
        end
    end

    // ************************************************************
    // soft refresh timer and row
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tmr_reg <= '0;
            due_reg <= 1'b0;
            row_reg <= '0;
        end
        else
        begin
            if (shadow_reg[`BCC_AUTO_REFRESH] || !soft_ref_on_reg)
            begin
                tmr_reg <= '0;
                due_reg <= 1'b0;
            end
            else if (tmr_reg == `BCC_TMR_W'(`BCC_ROW_CYCLES - 1))
            begin
                tmr_reg <= '0;
                due_reg <= 1'b1;
            end
            else
            begin
                tmr_reg <= tmr_reg + `BCC_TMR_W'(1);
                if (state_reg == BCC_REF_ROW)
                begin
                    due_reg <= 1'b0;
                end
            end
            if (cyc_done && (state_reg == BCC_REF_TAG))
            begin
                row_reg <= row_reg + `BCC_ROW_W'(1);
            end
        end
    end
endmodule
`default_nettype wire

/* File: rtl/bcc_defs.svh */
/*
 * constants of the backup cache control host: device register numbers,
 * control field positions, own register offsets and refresh timing.
 * assumes inclusion by bare name from the package and the host modules.
 */
`ifndef BCC_DEFS_SVH
`define BCC_DEFS_SVH

// ************************************************************
// device register numbers
// ************************************************************
`define BCC_PR_AW 7
`define BCC_PR_CTL 7'h77
`define BCC_PR_FLUSH_BT 7'h79
`define BCC_PR_FLUSH_PT 7'h7a
`define BCC_PR_ROW_CTR 7'h7c
`define BCC_PR_TAG_DATA 7'h7d

// ************************************************************
// cache_control_reg fields
// ************************************************************
`define BCC_CTL_W 5
`define BCC_FORCE_HIT 0
`define BCC_BACKUP_TAG_ON 1
`define BCC_PRIMARY_TAG_COPY_ON 2
`define BCC_AUTO_REFRESH 3
`define BCC_SLOW_RAM_SELECT 4
`define BCC_CTL_RESET 5'h00

// ************************************************************
// own apb registers
// ************************************************************
`define BCC_OFF_CTRL_REQ 12'h000
`define BCC_OFF_CMD 12'h004
`define BCC_OFF_STATUS 12'h008
`define BCC_OFF_READBACK 12'h00c
`define BCC_OFF_REFRESH_CFG 12'h010
`define BCC_REQ_ALLOW_OFF 8
`define BCC_CMD_READ 0
`define BCC_CMD_FLUSH_BT 1
`define BCC_CMD_FLUSH_PT 2
`define BCC_ST_BUSY 0
`define BCC_ST_REFUSED 1
`define BCC_ST_CTL_LSB 4
`define BCC_ST_ROW_LSB 16

// ************************************************************
// soft refresh timing
// ************************************************************
`define BCC_ROW_W 10
`define BCC_ROWS 1024
`define BCC_REFRESH_WINDOW_NS 1000000
`define BCC_CLK_NS 10
`define BCC_ROW_CYCLES ((`BCC_REFRESH_WINDOW_NS / `BCC_CLK_NS) / `BCC_ROWS)
`define BCC_TMR_W 17

`endif

/* File: rtl/bcc_pkg.sv */
/*
 * types of the backup cache control host.
 * assumes bcc_defs.svh on the include path.
 */
`include "bcc_defs.svh"

package bcc_pkg;
    typedef enum logic [7:0]
    {
        BCC_IDLE = 8'h01,
        BCC_FLUSH_BT = 8'h02,
        BCC_FLUSH_PT = 8'h04,
        BCC_PC_FLUSH = 8'h08,
        BCC_WR_CTL = 8'h10,
        BCC_RD_CTL = 8'h20,
        BCC_REF_ROW = 8'h40,
        BCC_REF_TAG = 8'h80
    } bcc_state_t;
endpackage

/* File: rtl/bcc_cycle.sv */
/*
 * one processor-register cycle on the device port: request held until ack.
 * assumes the device pulses ack for one cycle while the request stands.
 */
`timescale 1ns/10ps
`default_nettype none
`include "bcc_defs.svh"

module bcc_cycle
    import bcc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic write,
    input wire logic [`BCC_PR_AW-1:0] addr,
    input wire logic [31:0] wdata,
    output logic done,
    output logic [31:0] rdata,
    output logic pr_req,
    output logic pr_write,
    output logic [`BCC_PR_AW-1:0] pr_addr,
    output logic [31:0] pr_wdata,
    input wire logic pr_ack,
    input wire logic [31:0] pr_rdata
);
    // ************************************************************
    // request and completion
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pr_req <= 1'b0;
            pr_write <= 1'b0;
            pr_addr <= '0;
            pr_wdata <= 32'h0;
            done <= 1'b0;
            rdata <= 32'h0;
        end
        else
        begin
            done <= 1'b0;
            if (pr_req && pr_ack)
            begin
                pr_req <= 1'b0;
                done <= 1'b1;
                if (!pr_write)
                begin
                    rdata <= pr_rdata;
                end
            end
            else if (start && !pr_req)
            begin
                pr_req <= 1'b1;
                pr_write <= write;
                pr_addr <= addr;
                pr_wdata <= wdata;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verification/bcc_host_asserts.sv */
/* checker of bcc_host ports: apb timing, device cycle framing, control words.
   assumes binding to bcc_host and a single clock domain. */
`timescale 1ns/10ps
`default_nettype none
`include "bcc_defs.svh"
module bcc_host_asserts
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic mem_slow_ram,
    input wire logic pcache_on,
    input wire logic pcache_flush,
    input wire logic pr_req,
    input wire logic pr_write,
    input wire logic [`BCC_PR_AW-1:0] pr_addr,
    input wire logic [31:0] pr_wdata,
    input wire logic pr_ack
);
    // ************************************************************
    // properties
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic ctl_wr;
    assign ctl_wr = pr_req && pr_write && pr_addr == `BCC_PR_CTL;
    sequence apb_setup_s;
        psel && !penable;
    endsequence
    sequence apb_access_s;
        psel && penable;
    endsequence
    apb_wait_a: assert property (apb_setup_s ##1 apb_access_s |=> pready)
        else $error("pready not one cycle after access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    slverr_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata nonzero outside pready");
    req_hold_a: assert property (pr_req && !pr_ack |=> pr_req && $stable(pr_addr) && $stable(pr_wdata))
        else $error("device request changed before ack");
    req_drop_a: assert property (pr_req && pr_ack |=> !pr_req ##1 !pr_req)
        else $error("device request not released for two cycles");
    ctl_mbz_a: assert property (ctl_wr |-> pr_wdata[31:5] == 27'h0)
        else $error("control write upper bits nonzero");
    slow_copy_a: assert property (ctl_wr |-> pr_wdata[4] == mem_slow_ram)
        else $error("ram speed bit differs from memory side");
    copy_forced_a: assert property (ctl_wr && pcache_on |-> pr_wdata[2])
        else $error("primary copy off while primary cache on");
    force_needs_a: assert property (ctl_wr && pr_wdata[0] |-> pr_wdata[1])
        else $error("force hit without backup tag enable");
    flush_pulse_a: assert property (pcache_flush |-> !pr_req ##1 !pcache_flush)
        else $error("primary cache flush not a single pulse");
endmodule
bind bcc_host bcc_host_asserts u_bcc_host_asserts (.clk, .rst_n, .psel, .penable, .prdata, .pready, .pslverr,
    .mem_slow_ram, .pcache_on, .pcache_flush, .pr_req, .pr_write, .pr_addr, .pr_wdata, .pr_ack);
`default_nettype wire

/* File: verification/bcc_dev_model.sv */
/* model of the cache tag controller register port: control, flush, row counter.
   assumes requests held until the acknowledge edge. */
`timescale 1ns/10ps
`default_nettype none
`include "bcc_defs.svh"
module bcc_dev_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pr_req,
    input wire logic pr_write,
    input wire logic [`BCC_PR_AW-1:0] pr_addr,
    input wire logic [31:0] pr_wdata,
    output logic pr_ack,
    output logic [31:0] pr_rdata
);
    // ************************************************************
    // register port
    // ************************************************************
    logic [4:0] ctl_reg;
    logic [9:0] row_reg;
    logic [2:0] wait_reg;
    logic slow_reg;
    logic fire;
    logic done;
    int bt_flushes = 0;
    int pt_flushes = 0;
    int tag_reads = 0;
    assign fire = pr_req && !pr_ack && wait_reg == ((slow_reg || ctl_reg[4]) ? 3'h4 : 3'h0);
    assign done = pr_req && pr_ack;
    // alternate prompt and slow answers while ctl_reg[4] is clear; every answer slow while it is set
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pr_ack <= 1'b0;
            wait_reg <= 3'h0;
            slow_reg <= 1'b0;
        end
        else
        begin
            pr_ack <= fire;
            wait_reg <= (pr_req && !pr_ack && !fire) ? wait_reg + 3'h1 : 3'h0;
            slow_reg <= fire ? ~slow_reg : slow_reg;
        end
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ctl_reg <= 5'h00;
        else if (done && pr_write && pr_addr == `BCC_PR_CTL)
            ctl_reg <= pr_wdata[4:0];
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            row_reg <= 10'h000;
        else if (done && pr_write && pr_addr == `BCC_PR_ROW_CTR)
            row_reg <= pr_wdata[9:0];
        else if (ctl_reg[3])
            row_reg <= row_reg + 10'h001;
    end
    always_ff @(posedge clk)
    begin
        if (done && pr_write && pr_addr == `BCC_PR_FLUSH_BT)
            bt_flushes <= bt_flushes + 1;
        if (done && pr_write && pr_addr == `BCC_PR_FLUSH_PT)
            pt_flushes <= pt_flushes + 1;
        if (done && !pr_write && pr_addr == `BCC_PR_TAG_DATA)
            tag_reads <= tag_reads + 1;
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pr_rdata <= 32'h0;
        else if (fire && pr_addr == `BCC_PR_CTL)
            pr_rdata <= {27'h0, ctl_reg};
        else
            pr_rdata <= ~pr_rdata;
    end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
/* self-checking bench of bcc_host over apb with the device model.
   assumes bcc_pkg, bcc_defs.svh and the checker compiled first. */
`timescale 1ns/10ps
`default_nettype none
`include "bcc_defs.svh"
module tb_top;
    logic clk, rst_n, psel, penable, pwrite, mem_slow_ram, pcache_on, err;
    logic pready, pslverr, pcache_flush, pr_req, pr_write, pr_ack;
    logic [11:0] paddr;
    logic [6:0] pr_addr;
    logic [31:0] pwdata, prdata, pr_wdata, pr_rdata, rd;
    int mismatches = 0;
    int tests_run = 0;
    int n_pf = 0;
    bcc_host u_bcc_host (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .mem_slow_ram, .pcache_on, .pcache_flush, .pr_req, .pr_write, .pr_addr, .pr_wdata, .pr_ack, .pr_rdata);
    bcc_dev_model u_bcc_dev_model (.clk, .rst_n, .pr_req, .pr_write, .pr_addr, .pr_wdata, .pr_ack, .pr_rdata);
    // ************************************************************
    // tasks
    // ************************************************************
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
        if (pcache_flush === 1'b1)
            n_pf++;
    task give_verdict;
    begin
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
    begin
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (n >= 50)
        begin
            mismatches++;
            give_verdict;
        end
    end
    endtask
    task idle;
        int k;
    begin
        k = 0;
        do
        begin
            apb(1'b0, `BCC_OFF_STATUS, 32'h0);
            k++;
        end
        while (rd[0] !== 1'b0 && k < 500);
        if (k >= 500)
        begin
            mismatches++;
            give_verdict;
        end
    end
    endtask
    task req(input logic [31:0] d, input logic [4:0] exp);
    begin
        apb(1'b1, `BCC_OFF_CTRL_REQ, d);
        idle;
        apb(1'b0, `BCC_OFF_READBACK, 32'h0);
        chk(rd, {27'h0, exp});
        chk({27'h0, u_bcc_dev_model.ctl_reg}, {27'h0, exp});
    end
    endtask
    // ************************************************************
    // sequence
    // ************************************************************
    initial
    begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, mem_slow_ram} = '0;
        pcache_on = 1'b1;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({27'h0, u_bcc_dev_model.ctl_reg}, 32'h0);
        apb(1'b0, `BCC_OFF_REFRESH_CFG, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, `BCC_OFF_REFRESH_CFG, 32'h0);
        idle;
        apb(1'b0, `BCC_OFF_STATUS, 32'h0);
        chk(rd & 32'h1f3, 32'h0);
        req(32'h0a, 5'h0e);
        chk(u_bcc_dev_model.bt_flushes, 32'd1);
        mem_slow_ram <= 1'b1;
        req(32'h0b, 5'h1f);
        req(32'h0a, 5'h1e);
        chk(u_bcc_dev_model.bt_flushes, 32'd2);
        req(32'h08, 5'h1e);
        req(32'h109, 5'h1c);
        pcache_on <= 1'b0;
        req(32'h118, 5'h18);
        req(32'h0e, 5'h1e);
        chk(u_bcc_dev_model.bt_flushes, 32'd3);
        chk(u_bcc_dev_model.pt_flushes, 32'd2);
        chk(n_pf, 32'd2);
        apb(1'b1, `BCC_OFF_CMD, 32'h2);
        idle;
        apb(1'b1, `BCC_OFF_CMD, 32'h4);
        idle;
        chk(u_bcc_dev_model.bt_flushes, 32'd4);
        chk(u_bcc_dev_model.pt_flushes, 32'd3);
        apb(1'b1, `BCC_OFF_CMD, 32'h1);
        idle;
        chk({27'h0, rd[8:4]}, 32'h1e);
        apb(1'b1, `BCC_OFF_CTRL_REQ, 32'h0e);
        apb(1'b1, `BCC_OFF_CMD, 32'h2);
        idle;
        chk(rd & 32'h2, 32'h2);
        chk(u_bcc_dev_model.bt_flushes, 32'd4);
        apb(1'b1, `BCC_OFF_STATUS, 32'h2);
        apb(1'b0, `BCC_OFF_STATUS, 32'h0);
        chk(rd & 32'h2, 32'h0);
        apb(1'b0, 12'h014, 32'h0);
        chk({31'h0, err}, 32'h1);
        req(32'h106, 5'h16);
        apb(1'b1, `BCC_OFF_REFRESH_CFG, 32'h1);
        repeat (400) @(posedge clk);
        chk({31'h0, u_bcc_dev_model.tag_reads >= 3}, 32'h1);
        give_verdict;
    end
endmodule
`default_nettype wire
